// [hdl/t16ca_cfg.svh]
// address map, reset values and space limits for the timer16 count/compare access block
`ifndef T16CA_CFG_SVH
`define T16CA_CFG_SVH

// low I/O range as seen by the I/O-port instructions
`define T16CA_IO_FIRST      16'h0000
`define T16CA_IO_LAST       16'h003F
// offset added when a low-range register is reached through data space
`define T16CA_IO_DATA_BIAS  16'h0020
// first data address of the extended I/O area
`define T16CA_EXT_BASE      16'h0060

// low-range registers, I/O offsets
`define T16CA_IO_CMP1B_LO   16'h0028
`define T16CA_IO_CMP1B_HI   16'h0029
`define T16CA_IO_CMP1A_LO   16'h002A
`define T16CA_IO_CMP1A_HI   16'h002B
`define T16CA_IO_CNT1_LO    16'h002C
`define T16CA_IO_CNT1_HI    16'h002D

// extended-area registers, data addresses
`define T16CA_EXT_CMP1C_LO  16'h0078
`define T16CA_EXT_CNT3_LO   16'h0088
`define T16CA_EXT_CNT3_HI   16'h0089

// reset values
`define T16CA_RESET_BYTE    8'h00
`define T16CA_RESET_WORD    16'h0000
// value returned for an unmapped read
`define T16CA_IDLE_BYTE     8'h00

`endif

// [hdl/t16ca_pkg.sv]
// types shared by the timer16 count/compare access block
package t16ca_pkg;

  // one CPU access request, sampled on the rising edge of clk
  typedef struct packed {
    logic        io_space;  // 1: I/O-port instruction, 0: data-space load/store
    logic [15:0] addr;      // I/O offset or data address
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } t16ca_bus_s;

  // decoded target of an access
  typedef enum logic [3:0] {
    T16CA_SEL_NONE    = 4'h0,
    T16CA_SEL_CMP1B_L = 4'h1,
    T16CA_SEL_CMP1B_H = 4'h2,
    T16CA_SEL_CMP1A_L = 4'h3,
    T16CA_SEL_CMP1A_H = 4'h4,
    T16CA_SEL_CNT1_L  = 4'h5,
    T16CA_SEL_CNT1_H  = 4'h6,
    T16CA_SEL_CMP1C_L = 4'h7,
    T16CA_SEL_CNT3_L  = 4'h8,
    T16CA_SEL_CNT3_H  = 4'h9
  } t16ca_sel_e;

  // timer1 compare match pulses
  typedef struct packed {
    logic a;
    logic b;
    logic c;
  } t16ca_match_s;

endpackage

// [hdl/t16ca_reg16.sv]
// 16-bit holding register loaded as one word
`include "t16ca_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module t16ca_reg16
  import t16ca_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        load,
  input  wire logic [15:0] load_value,
  output var  logic [15:0] value
);

  logic [15:0] value_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      value_q <= `T16CA_RESET_WORD;
    end else if (load) begin
      value_q <= load_value;
    end
  end

  assign value = value_q;

endmodule

`default_nettype wire

// [hdl/t16ca_counter.sv]
// 16-bit up counter with word load and one-tick compare match suppression
`include "t16ca_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module t16ca_counter
  import t16ca_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        tick,
  input  wire logic        load,
  input  wire logic [15:0] load_value,
  output var  logic [15:0] count,
  output var  logic        block,
  output var  logic        match_enable
);

  logic [15:0] count_q;
  logic        block_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q <= `T16CA_RESET_WORD;
    end else if (load) begin
      count_q <= load_value;
    end else if (tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // a write arms the block; the next tick consumes it, a write in the same cycle re-arms
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      block_q <= 1'b0;
    end else if (load) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  assign count        = count_q;
  assign block        = block_q;
  assign match_enable = tick & ~block_q & ~load;

endmodule

`default_nettype wire

// [hdl/t16ca_access.sv]
// register access for timer1/timer3 counters and timer1 compare values
`include "t16ca_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module t16ca_access
  import t16ca_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire t16ca_bus_s   bus,
  output var  logic [7:0]   rdata,
  output var  logic         rd_hit,
  input  wire logic         timer1_tick,
  input  wire logic         timer3_tick,
  input  wire logic [7:0]   compare_c_high_in,
  output var  logic [15:0]  timer1_count,
  output var  logic [15:0]  timer3_count,
  output var  logic [15:0]  compare_a,
  output var  logic [15:0]  compare_b,
  output var  logic [7:0]   compare_c_low,
  output var  t16ca_match_s timer1_match,
  output var  logic         timer3_match_block
);

  logic [15:0]  data_addr;
  logic         space_ok;
  t16ca_sel_e   sel;
  logic         rd_req;
  logic [7:0]   temp_q;
  logic [7:0]   rdata_q;
  logic [7:0]   rdata_d;
  logic         rd_hit_q;
  logic [7:0]   cmp_c_low_q;
  t16ca_match_s match_q;
  logic [15:0]  commit_word;
  logic         load_cnt1;
  logic         load_cnt3;
  logic         load_cmp_a;
  logic         load_cmp_b;
  logic [15:0]  cnt1_value;
  logic [15:0]  cnt3_value;
  logic [15:0]  cmp_a_value;
  logic [15:0]  cmp_b_value;
  logic         cnt1_match_en;
  logic         cnt3_block;

  // translate the request into one data address; I/O offsets above the low range are dropped
  always_comb begin
    if (bus.io_space) begin
      space_ok  = (bus.addr <= `T16CA_IO_LAST);
      data_addr = bus.addr + `T16CA_IO_DATA_BIAS;
    end else begin
      space_ok  = 1'b1;
      data_addr = bus.addr;
    end
  end

  // the I/O window maps only onto 0x20..0x5F, so the extended area is unreachable from it
  always_comb begin
    sel = T16CA_SEL_NONE;
    if (space_ok) begin
      unique case (data_addr)
        `T16CA_IO_CMP1B_LO + `T16CA_IO_DATA_BIAS: sel = T16CA_SEL_CMP1B_L;
        `T16CA_IO_CMP1B_HI + `T16CA_IO_DATA_BIAS: sel = T16CA_SEL_CMP1B_H;
        `T16CA_IO_CMP1A_LO + `T16CA_IO_DATA_BIAS: sel = T16CA_SEL_CMP1A_L;
        `T16CA_IO_CMP1A_HI + `T16CA_IO_DATA_BIAS: sel = T16CA_SEL_CMP1A_H;
        `T16CA_IO_CNT1_LO + `T16CA_IO_DATA_BIAS:  sel = T16CA_SEL_CNT1_L;
        `T16CA_IO_CNT1_HI + `T16CA_IO_DATA_BIAS:  sel = T16CA_SEL_CNT1_H;
        `T16CA_EXT_CMP1C_LO: begin
          if (!bus.io_space) begin
            sel = T16CA_SEL_CMP1C_L;
          end
        end
        `T16CA_EXT_CNT3_LO: begin
          if (!bus.io_space) begin
            sel = T16CA_SEL_CNT3_L;
          end
        end
        `T16CA_EXT_CNT3_HI: begin
          if (!bus.io_space) begin
            sel = T16CA_SEL_CNT3_H;
          end
        end
        default: sel = T16CA_SEL_NONE;
      endcase
    end
  end

  // a write takes precedence if both strobes are raised together
  assign rd_req = bus.rd & ~bus.wr;

  // low-byte write commits the latched high byte together with the new low byte
  assign commit_word = {temp_q, bus.wdata};

  assign load_cnt1  = bus.wr & (sel == T16CA_SEL_CNT1_L);
  assign load_cnt3  = bus.wr & (sel == T16CA_SEL_CNT3_L);
  assign load_cmp_a = bus.wr & (sel == T16CA_SEL_CMP1A_L);
  assign load_cmp_b = bus.wr & (sel == T16CA_SEL_CMP1B_L);

  // single latch for every 16-bit register: fed by high-byte writes and low-byte reads
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      temp_q <= `T16CA_RESET_BYTE;
    end else if (bus.wr) begin
      unique case (sel)
        T16CA_SEL_CMP1B_H,
        T16CA_SEL_CMP1A_H,
        T16CA_SEL_CNT1_H,
        T16CA_SEL_CNT3_H: temp_q <= bus.wdata;
        default:          temp_q <= temp_q;
      endcase
    end else if (rd_req) begin
      unique case (sel)
        T16CA_SEL_CMP1B_L: temp_q <= cmp_b_value[15:8];
        T16CA_SEL_CMP1A_L: temp_q <= cmp_a_value[15:8];
        T16CA_SEL_CNT1_L:  temp_q <= cnt1_value[15:8];
        T16CA_SEL_CNT3_L:  temp_q <= cnt3_value[15:8];
        default:           temp_q <= temp_q;
      endcase
    end
  end

  t16ca_counter u_timer1_counter (
    .clk          (clk),
    .reset        (reset),
    .tick         (timer1_tick),
    .load         (load_cnt1),
    .load_value   (commit_word),
    .count        (cnt1_value),
    .block        (),
    .match_enable (cnt1_match_en)
  );

  t16ca_counter u_timer3_counter (
    .clk          (clk),
    .reset        (reset),
    .tick         (timer3_tick),
    .load         (load_cnt3),
    .load_value   (commit_word),
    .count        (cnt3_value),
    .block        (cnt3_block),
    .match_enable ()
  );

  t16ca_reg16 u_compare_a (
    .clk        (clk),
    .reset      (reset),
    .load       (load_cmp_a),
    .load_value (commit_word),
    .value      (cmp_a_value)
  );

  t16ca_reg16 u_compare_b (
    .clk        (clk),
    .reset      (reset),
    .load       (load_cmp_b),
    .load_value (commit_word),
    .value      (cmp_b_value)
  );

  // the high half of compare C lives outside this block, so the low byte stands alone
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmp_c_low_q <= `T16CA_RESET_BYTE;
    end else if (bus.wr && sel == T16CA_SEL_CMP1C_L) begin
      cmp_c_low_q <= bus.wdata;
    end
  end

  // compare on the count present at the tick; a pending counter write masks all three units
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      match_q <= '0;
    end else begin
      match_q.a <= cnt1_match_en & (cnt1_value == cmp_a_value);
      match_q.b <= cnt1_match_en & (cnt1_value == cmp_b_value);
      match_q.c <= cnt1_match_en & (cnt1_value == {compare_c_high_in, cmp_c_low_q});
    end
  end

  // read mux: low bytes give the live value, high bytes give the latch
  always_comb begin
    rdata_d = `T16CA_IDLE_BYTE;
    unique case (sel)
      T16CA_SEL_CMP1B_L: rdata_d = cmp_b_value[7:0];
      T16CA_SEL_CMP1A_L: rdata_d = cmp_a_value[7:0];
      T16CA_SEL_CNT1_L:  rdata_d = cnt1_value[7:0];
      T16CA_SEL_CNT3_L:  rdata_d = cnt3_value[7:0];
      T16CA_SEL_CMP1C_L: rdata_d = cmp_c_low_q;
      T16CA_SEL_CMP1B_H,
      T16CA_SEL_CMP1A_H,
      T16CA_SEL_CNT1_H,
      T16CA_SEL_CNT3_H:  rdata_d = temp_q;
      default:           rdata_d = `T16CA_IDLE_BYTE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q  <= `T16CA_IDLE_BYTE;
      rd_hit_q <= 1'b0;
    end else begin
      rdata_q  <= rd_req ? rdata_d : `T16CA_IDLE_BYTE;
      rd_hit_q <= rd_req & (sel != T16CA_SEL_NONE);
    end
  end

  assign rdata              = rdata_q;
  assign rd_hit             = rd_hit_q;
  assign timer1_count       = cnt1_value;
  assign timer3_count       = cnt3_value;
  assign compare_a          = cmp_a_value;
  assign compare_b          = cmp_b_value;
  assign compare_c_low      = cmp_c_low_q;
  assign timer1_match       = match_q;
  assign timer3_match_block = cnt3_block;

endmodule

`default_nettype wire

// [verification/t16ca_access_chk.sv]
// concurrent checks on the ports of the count/compare access block
`timescale 1ns/100ps
`default_nettype none

module t16ca_access_chk
  import t16ca_pkg::*;
(
  input wire logic         clk,
  input wire logic         reset,
  input wire t16ca_bus_s   bus,
  input wire logic [7:0]   rdata,
  input wire logic         rd_hit,
  input wire logic         timer1_tick,
  input wire logic         timer3_tick,
  input wire logic [7:0]   compare_c_high_in,
  input wire logic [15:0]  timer1_count,
  input wire logic [15:0]  timer3_count,
  input wire logic [15:0]  compare_a,
  input wire logic [15:0]  compare_b,
  input wire logic [7:0]   compare_c_low,
  input wire t16ca_match_s timer1_match,
  input wire logic         timer3_match_block
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  wire logic io_rd   = bus.io_space && bus.rd && !bus.wr;
  wire logic dat_rd  = !bus.io_space && bus.rd && !bus.wr;
  wire logic dat_wr  = !bus.io_space && bus.wr;
  wire logic c1_wr   = bus.wr && (bus.addr == (bus.io_space ? 16'h002C : 16'h004C));

  sequence s_hi_wr;
    dat_wr && bus.addr == 16'h004D;
  endsequence
  sequence s_lo_wr;
    dat_wr && bus.addr == 16'h004C;
  endsequence
  // a counter write stays pending until the next timer1 tick consumes it; any gap length
  logic c1_armed_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      c1_armed_q <= 1'b0;
    end else if (c1_wr) begin
      c1_armed_q <= 1'b1;
    end else if (timer1_tick) begin
      c1_armed_q <= 1'b0;
    end
  end

  sequence s_load_then_tick;
    timer1_tick && (c1_wr || c1_armed_q);
  endsequence
  sequence s_io_a_pair;
    bus.io_space && bus.wr && bus.addr == 16'h002B ##1 bus.io_space && bus.wr && bus.addr == 16'h002A;
  endsequence
  sequence s_dat_b_pair;
    dat_wr && bus.addr == 16'h0049 ##1 dat_wr && bus.addr == 16'h0048;
  endsequence

  property p_pair_write;
    s_hi_wr ##1 s_lo_wr |=> timer1_count == {$past(bus.wdata, 2), $past(bus.wdata)};
  endproperty
  property p_io_lo_read;
    io_rd && bus.addr == 16'h002C |=> rd_hit && rdata == $past(timer1_count[7:0]);
  endproperty
  property p_io_range;
    io_rd && bus.addr > 16'h003F |=> !rd_hit && rdata == 8'h00;
  endproperty
  property p_ext_read;
    dat_rd && bus.addr == 16'h0088 |=> rd_hit && rdata == $past(timer3_count[7:0]);
  endproperty
  property p_ext_c_write;
    dat_wr && bus.addr == 16'h0078 |=> compare_c_low == $past(bus.wdata);
  endproperty
  property p_cnt1_block;
    s_load_then_tick |=> timer1_match == 3'h0;
  endproperty
  property p_cnt3_block_set;
    dat_wr && bus.addr == 16'h0088 |=> timer3_match_block;
  endproperty
  property p_cnt3_block_clr;
    timer3_match_block && timer3_tick && !bus.wr |=> !timer3_match_block;
  endproperty
  property p_cnt1_inc;
    timer1_tick && !bus.wr |=> timer1_count == $past(timer1_count) + 16'h0001;
  endproperty
  property p_cmp_a_pair;
    s_io_a_pair |=> compare_a == {$past(bus.wdata, 2), $past(bus.wdata)};
  endproperty
  property p_cmp_b_pair;
    s_dat_b_pair |=> compare_b == {$past(bus.wdata, 2), $past(bus.wdata)};
  endproperty

  a_pair_write: assert property (p_pair_write)
    else $error("word write did not commit latch and low byte");
  a_io_lo_read: assert property (p_io_lo_read)
    else $error("low count byte read wrong");
  a_io_range: assert property (p_io_range)
    else $error("port access beyond low range answered");
  a_ext_read: assert property (p_ext_read)
    else $error("timer3 low byte read wrong");
  a_ext_c_write: assert property (p_ext_c_write)
    else $error("compare c low write lost");
  a_cnt1_block: assert property (p_cnt1_block)
    else $error("match after counter load not suppressed");
  a_cnt3_block_set: assert property (p_cnt3_block_set)
    else $error("timer3 block not raised by write");
  a_cnt3_block_clr: assert property (p_cnt3_block_clr)
    else $error("timer3 block held past tick");
  a_cnt1_inc: assert property (p_cnt1_inc)
    else $error("count did not step on tick");
  a_cmp_a_pair: assert property (p_cmp_a_pair)
    else $error("compare a word write through port space lost");
  a_cmp_b_pair: assert property (p_cmp_b_pair)
    else $error("compare b word write through data space lost");
endmodule

bind t16ca_access t16ca_access_chk u_chk (.clk, .reset, .bus, .rdata, .rd_hit, .timer1_tick,
  .timer3_tick, .compare_c_high_in, .timer1_count, .timer3_count, .compare_a, .compare_b,
  .compare_c_low, .timer1_match, .timer3_match_block);

`default_nettype wire

// [verification/test_timer16_count_compare_access.sv]
// self-checking bench for the count/compare access block
`timescale 1ns/100ps
`default_nettype none

module test_timer16_count_compare_access
  import t16ca_pkg::*;
();
  logic         clk;
  logic         reset;
  t16ca_bus_s   bus;
  logic         t1_tick;
  logic         t3_tick;
  logic [7:0]   c_high;
  logic [7:0]   rdata;
  logic         rd_hit;
  logic [15:0]  cnt1;
  logic [15:0]  cnt3;
  logic [15:0]  cmp_a;
  logic [15:0]  cmp_b;
  logic [7:0]   cmp_cl;
  t16ca_match_s match1;
  logic         blk3;
  int           n_mismatch;
  int           tests_run;

  t16ca_access DUT (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .rd_hit(rd_hit),
    .timer1_tick(t1_tick), .timer3_tick(t3_tick), .compare_c_high_in(c_high),
    .timer1_count(cnt1), .timer3_count(cnt3), .compare_a(cmp_a), .compare_b(cmp_b),
    .compare_c_low(cmp_cl), .timer1_match(match1), .timer3_match_block(blk3));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one bus cycle; strobes stay up until the next call so no signal toggles twice per step
  task automatic drv(input logic io, input logic [15:0] a, input logic w, input logic r,
                     input logic [7:0] d, input logic t1, input logic t3);
    bus = '{io, a, w, r, d};
    t1_tick = t1;
    t3_tick = t3;
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic io, input logic [15:0] a, input logic [7:0] d);
    drv(io, a, 1'b1, 1'b0, d, 1'b0, 1'b0);
  endtask

  task automatic rd(input logic io, input logic [15:0] a, input logic [7:0] e, input logic h);
    drv(io, a, 1'b0, 1'b1, 8'h00, 1'b0, 1'b0);
    chk("rdata", {8'h00, e}, {8'h00, rdata});
    chk("rd_hit", {15'h0000, h}, {15'h0000, rd_hit});
  endtask

  task automatic idle();
    drv(1'b0, 16'h0000, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
  endtask

  task automatic tick1(input logic [2:0] e);
    drv(1'b0, 16'h0000, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0);
    chk("timer1_match", {13'h0000, e}, {13'h0000, match1});
  endtask

  logic [16:0] regs [9] = '{17'h1_0028, 17'h1_0029, 17'h1_002A, 17'h1_002B, 17'h1_002C,
                            17'h1_002D, 17'h0_0078, 17'h0_0088, 17'h0_0089};

  initial begin
    n_mismatch = 0;
    tests_run = 0;
    reset = 1'b1;
    c_high = 8'h00;
    bus = '0;
    t1_tick = 1'b0;
    t3_tick = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    foreach (regs[i]) rd(regs[i][16], regs[i][15:0], 8'h00, 1'b1);
    wr(1'b1, 16'h002D, 8'h12);
    wr(1'b1, 16'h002C, 8'h34);
    chk("timer1_count", 16'h1234, cnt1);
    rd(1'b0, 16'h004C, 8'h34, 1'b1);
    rd(1'b0, 16'h004D, 8'h12, 1'b1);
    // a high byte parked for compare a ends up in timer3: one latch for all words
    wr(1'b1, 16'h002B, 8'hAB);
    wr(1'b0, 16'h0088, 8'h5A);
    chk("timer3_count", 16'hAB5A, cnt3);
    rd(1'b1, 16'h002C, 8'h34, 1'b1);
    rd(1'b0, 16'h004B, 8'h12, 1'b1);
    wr(1'b1, 16'h002B, 8'h00);
    wr(1'b1, 16'h002A, 8'h10);
    chk("compare_a", 16'h0010, cmp_a);
    wr(1'b0, 16'h0049, 8'h43);
    wr(1'b0, 16'h0048, 8'h21);
    chk("compare_b", 16'h4321, cmp_b);
    wr(1'b0, 16'h0078, 8'h10);
    rd(1'b0, 16'h0078, 8'h10, 1'b1);
    wr(1'b1, 16'h0078, 8'hEE);
    chk("compare_c_low", 16'h0010, {8'h00, cmp_cl});
    rd(1'b1, 16'h0088, 8'h00, 1'b0);
    rd(1'b0, 16'h002C, 8'h00, 1'b0);
    wr(1'b1, 16'h002D, 8'h00);
    wr(1'b1, 16'h002C, 8'h10);
    idle();
    tick1(3'b000);
    chk("timer1_count", 16'h0011, cnt1);
    wr(1'b0, 16'h004D, 8'h00);
    wr(1'b0, 16'h004C, 8'h0F);
    idle();
    tick1(3'b000);
    tick1(3'b101);
    wr(1'b0, 16'h0089, 8'h00);
    wr(1'b0, 16'h0088, 8'h05);
    idle();
    chk("timer3_match_block", 16'h0001, {15'h0000, blk3});
    drv(1'b0, 16'h0000, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1);
    chk("timer3_match_block", 16'h0000, {15'h0000, blk3});
    chk("timer3_count", 16'h0006, cnt3);
    idle();
    complete_run();
  end

  // the sequence needs well under a hundred cycles
  initial begin
    repeat (1000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
endmodule

`default_nettype wire
